// *** shared/store_seq_pkg.sv ***
// Constants for the eeprom store sequencer
package store_seq_pkg;
  // ----------------------------------------
  // Register word indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [13:0] IDX_CTRL                   = 14'h0000;
  localparam logic [13:0] IDX_STATUS                 = 14'h0001;
  localparam logic [13:0] IDX_POINTER                = 14'h0002;
  localparam logic [13:0] IDX_SCRATCH_STORE_INSTR    = 14'h0e11;
  localparam logic [13:0] IDX_SCRATCH_START_ADDR_HIGH = 14'h0e12;
  localparam logic [13:0] IDX_SCRATCH_START_ADDR_LOW = 14'h0e13;
  localparam logic [13:0] IDX_PIN_IRQ_STORE_INSTR    = 14'h0e14;
  localparam logic [13:0] IDX_PIN_IRQ_START_ADDR_HIGH = 14'h0e15;
  localparam logic [13:0] IDX_PIN_IRQ_START_ADDR_LOW = 14'h0e16;
  localparam logic [13:0] IDX_SYS_CLOCK_STORE_INSTR  = 14'h0e17;
  localparam logic [13:0] IDX_SYS_CLOCK_START_ADDR_HIGH = 14'h0e18;
  localparam logic [13:0] IDX_SYS_CLOCK_START_ADDR_LOW = 14'h0e19;
  localparam logic [13:0] IDX_APPLY_UPDATE_STEP      = 14'h0e1a;
  localparam logic [13:0] IDX_CLOCK_CALIBRATE_STEP   = 14'h0e1b;

  // ----------------------------------------
  // Sequence storage
  // ----------------------------------------
  localparam int          SEQ_LEN  = 11;
  localparam logic [3:0]  SEQ_LAST = 4'ha;
  localparam logic [13:0] SEQ_FIRST_IDX = IDX_SCRATCH_STORE_INSTR;
  localparam logic [13:0] SEQ_LAST_IDX  = IDX_CLOCK_CALIBRATE_STEP;
  localparam logic [7:0]  SEQ_RESET [0:SEQ_LEN-1] = '{
    8'h01, 8'h00, 8'hfe,   // Scratchpad: 2 bytes from 0x00fe
    8'h1f, 8'h01, 8'h00,   // Pins and irq masks: 32 bytes from 0x0100
    8'h08, 8'h02, 8'h00,   // Timebase clock: 9 bytes from 0x0200
    8'h80,                 // Apply update
    8'h91                  // Calibrate timebase clock
  };

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_START_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam logic [2:0] DATA_INSTR_TOP = 3'h0;  // bits 7:5 of a data instr
endpackage

// *** shared/seq_if.sv ***
// Link between the register file and the store engine
`timescale 1ns/100ps
interface seq_if;
  logic [3:0]  rd_idx;   // Sequence entry being read
  logic [7:0]  rd_byte;  // Entry contents
  logic        start;    // Store request pulse
  logic        busy;     // Store in progress
  logic        done;     // Store finished pulse
  logic [15:0] ptr;      // Eeprom address pointer
  modport regs (input rd_idx, busy, done, ptr, output rd_byte, start);
  modport core (output rd_idx, busy, done, ptr, input rd_byte, start);
endinterface

// *** hw/seq_regs.sv ***
// APB register file holding the store sequence and control
`timescale 1ns/100ps
module seq_regs (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Async reset, low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [15:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic             pready,   // APB ready
  output logic [31:0]      prdata,   // APB read data
  output logic             pslverr,  // APB error
  seq_if.regs              sq        // To store engine
);
  logic [7:0]  seq [0:store_seq_pkg::SEQ_LEN-1];
  logic        done_flag;
  wire  [13:0] word    = paddr[15:2];
  wire         access  = psel && penable;
  wire         commit  = access && pready && pwrite;
  wire         seq_hit = (word >= store_seq_pkg::SEQ_FIRST_IDX) &&
                         (word <= store_seq_pkg::SEQ_LAST_IDX);
  wire  [3:0]  seq_off = 4'(word - store_seq_pkg::SEQ_FIRST_IDX);
  wire         ctrl_hit = word == store_seq_pkg::IDX_CTRL;
  wire         stat_hit = word == store_seq_pkg::IDX_STATUS;
  wire         ptr_hit  = word == store_seq_pkg::IDX_POINTER;
  wire         mapped   = seq_hit || ctrl_hit || stat_hit || ptr_hit;
  wire  [31:0] rd_mux   = seq_hit  ? {24'h000000, seq[seq_off]} :
                          stat_hit ? {30'h00000000, done_flag, sq.busy} :
                          ptr_hit  ? {16'h0000, sq.ptr} : 32'h00000000;
  assign sq.rd_byte = seq[sq.rd_idx];

  // ----------------------------------------
  // Sequence entries, reset to the default store list
  // ----------------------------------------
  for (genvar i = 0; i < store_seq_pkg::SEQ_LEN; i++) begin : g_seq
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        seq[i] <= store_seq_pkg::SEQ_RESET[i];
      else if (commit && seq_hit && seq_off == 4'(i))
        seq[i] <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Bus answer, one wait state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      prdata    <= 32'h00000000;
      pslverr   <= 1'b0;
      sq.start  <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      pready    <= access && !pready;
      prdata    <= (access && !pready && !pwrite) ? rd_mux : 32'h00000000;
      pslverr   <= access && !pready && !mapped;
      sq.start  <= commit && ctrl_hit && !sq.busy &&
                   pwdata[store_seq_pkg::CTRL_START_BIT];
      done_flag <= sq.done || (done_flag && !sq.start);
    end
  end
endmodule // seq_regs

// *** hw/eeprom_store_sequencer.sv ***
// Store engine copying the sequence list and register map to eeprom
//
// Operation
// - A data instruction of value N asks for N+1 bytes, start address in the next two entries.
// - A data instruction byte is written to eeprom first, then the pointer steps by one.
// - The two start address bytes follow it, stepping the pointer by two.
// - N+1 register map bytes from the start address follow, stepping the pointer by the count.
// - The apply-update code is written unchanged with one pointer step and no copy.
// - The calibrate code is written unchanged with one pointer step.
// - The scratchpad entry defaults to copying two bytes from 0x00fe.
// - The pin and irq mask entry defaults to 0x1f from 0x0100, thirty-two bytes.
// - The timebase clock entry defaults to 0x08 from 0x0200, nine bytes.
`timescale 1ns/100ps
module eeprom_store_sequencer (
  input  wire logic        pclk,       // Clock, 100 MHz
  input  wire logic        presetn,    // Async reset, low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [15:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic             pready,     // APB ready
  output logic [31:0]      prdata,     // APB read data
  output logic             pslverr,    // APB error
  output logic             map_rd,     // Register map read pulse
  output logic [15:0]      map_addr,   // Register map address
  input  wire logic [7:0]  map_rdata,  // Map data, 2 edges after map_rd
  output logic             ee_valid,   // Eeprom byte write request
  output logic [15:0]      ee_addr,    // Eeprom byte address
  output logic [7:0]       ee_data,    // Eeprom byte
  input  wire logic        ee_ready,   // Eeprom byte accepted
  output logic             store_busy  // Store in progress
);
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_LOAD    = 3'b001,
    S_SEQ_WR  = 3'b010,
    S_MAP_RD  = 3'b011,
    S_MAP_WT  = 3'b100,
    S_MAP_CAP = 3'b101,
    S_MAP_WR  = 3'b110
  } state_type;

  seq_if sq ();

  state_type   state;
  logic [3:0]  idx;
  logic [1:0]  phase;
  logic [7:0]  cur_instr;
  logic [15:0] start_addr;
  logic [4:0]  cnt;
  logic [15:0] ptr;
  logic        done;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  seq_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .sq      (sq.regs)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [7:0] seq_byte = sq.rd_byte;
  wire       is_data  = cur_instr[7:5] == store_seq_pkg::DATA_INSTR_TOP;
  wire       accepted = ee_valid && ee_ready;
  wire       seq_end  = idx > store_seq_pkg::SEQ_LAST;
  wire       last_map = cnt == 5'h00;

  assign sq.rd_idx = idx;
  assign sq.busy   = store_busy;
  assign sq.done   = done;
  assign sq.ptr    = ptr;

  // ----------------------------------------
  // Store engine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      idx        <= 4'h0;
      phase      <= 2'h0;
      cur_instr  <= 8'h00;
      start_addr <= 16'h0000;
      cnt        <= 5'h00;
      ptr        <= 16'h0000;
      done       <= 1'b0;
      store_busy <= 1'b0;
      map_rd     <= 1'b0;
      map_addr   <= 16'h0000;
      ee_valid   <= 1'b0;
      ee_addr    <= 16'h0000;
      ee_data    <= 8'h00;
    end else begin
      done   <= 1'b0;
      map_rd <= 1'b0;
      case (state)
        S_IDLE: begin
          if (sq.start) begin
            ptr        <= 16'h0000;
            idx        <= 4'h0;
            phase      <= 2'h0;
            store_busy <= 1'b1;
            state      <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (seq_end) begin
            store_busy <= 1'b0;
            done       <= 1'b1;
            state      <= S_IDLE;
          end else begin
            ee_valid <= 1'b1;
            ee_addr  <= ptr;
            ee_data  <= seq_byte;
            case (phase)
              2'h0:    cur_instr <= seq_byte;
              2'h1:    start_addr[15:8] <= seq_byte;
              default: start_addr[7:0]  <= seq_byte;
            endcase
            state <= S_SEQ_WR;
          end
        end
        S_SEQ_WR: begin
          if (accepted) begin
            ee_valid <= 1'b0;
            ptr      <= ptr + 16'h0001;
            idx      <= idx + 4'h1;
            if (phase == 2'h0 && is_data) begin
              phase <= 2'h1;
              state <= S_LOAD;
            end else if (phase == 2'h1) begin
              phase <= 2'h2;
              state <= S_LOAD;
            end else if (phase == 2'h2) begin
              phase    <= 2'h0;
              cnt      <= cur_instr[4:0];
              map_addr <= start_addr;
              state    <= S_MAP_RD;
            end else begin
              phase <= 2'h0;
              state <= S_LOAD;
            end
          end
        end
        S_MAP_RD: begin
          map_rd <= 1'b1;
          state  <= S_MAP_WT;
        end
        S_MAP_WT: begin
          state <= S_MAP_CAP;
        end
        S_MAP_CAP: begin
          ee_valid <= 1'b1;
          ee_addr  <= ptr;
          ee_data  <= map_rdata;
          state    <= S_MAP_WR;
        end
        S_MAP_WR: begin
          if (accepted) begin
            ee_valid <= 1'b0;
            ptr      <= ptr + 16'h0001;
            if (last_map) begin
              state <= S_LOAD;
            end else begin
              cnt      <= cnt - 5'h01;
              map_addr <= map_addr + 16'h0001;
              state    <= S_MAP_RD;
            end
          end
        end
        default: begin
          store_busy <= 1'b0;
          ee_valid   <= 1'b0;
          state      <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_data_count;
    @(posedge pclk) disable iff (!presetn)
    (state == S_SEQ_WR && accepted && phase == 2'h2) |=>
      (cnt == cur_instr[4:0] && map_addr == start_addr &&
       state == S_MAP_RD);
  endproperty
  a_data_count: assert property (p_data_count)
    else $error("data count or start address not loaded");

  property p_instr_first;
    @(posedge pclk) disable iff (!presetn)
    (state == S_LOAD && phase == 2'h0 && !seq_end) |=>
      (ee_valid && ee_data == $past(seq_byte) && ee_addr == $past(ptr));
  endproperty
  a_instr_first: assert property (p_instr_first)
    else $error("instruction byte not written at pointer");

  property p_seq_step;
    @(posedge pclk) disable iff (!presetn)
    (state == S_SEQ_WR && accepted) |=>
      (ptr == $past(ptr) + 16'h0001 && !ee_valid);
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("pointer not stepped after sequence byte");

  property p_map_data;
    @(posedge pclk) disable iff (!presetn)
    map_rd |=> ##1 (ee_valid && ee_data == $past(map_rdata) &&
                    ee_addr == ptr);
  endproperty
  a_map_data: assert property (p_map_data)
    else $error("map byte not forwarded to eeprom");

  property p_map_next;
    @(posedge pclk) disable iff (!presetn)
    (state == S_MAP_WR && accepted && !last_map) |=>
      (map_addr == $past(map_addr) + 16'h0001 && state == S_MAP_RD)
      ##1 (map_rd && !ee_valid);
  endproperty
  a_map_next: assert property (p_map_next)
    else $error("map address not advanced");

  property p_single_step;
    @(posedge pclk) disable iff (!presetn)
    (state == S_SEQ_WR && accepted && phase == 2'h0 && !is_data) |=>
      (state == S_LOAD && phase == 2'h0 && !map_rd);
  endproperty
  a_single_step: assert property (p_single_step)
    else $error("command byte triggered a copy");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
    (state == S_SEQ_WR && accepted) |=> (idx == $past(idx) + 4'h1);
  endproperty
  a_order: assert property (p_order)
    else $error("sequence entries not walked in order");

  property p_start_clear;
    @(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && sq.start) |=>
      (ptr == 16'h0000 && idx == 4'h0 && store_busy) ##1 ee_valid;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("store did not start from pointer zero");

  property p_write_held;
    @(posedge pclk) disable iff (!presetn)
    (ee_valid && !ee_ready) |=> (ee_valid && $stable(ee_data) &&
                                 $stable(ee_addr));
  endproperty
  a_write_held: assert property (p_write_held)
    else $error("eeprom request dropped before acceptance");

  property p_addr_high;
    @(posedge pclk) disable iff (!presetn)
    (state == S_LOAD && phase == 2'h1 && !seq_end) |=>
      (start_addr[15:8] == $past(seq_byte) && ee_data == $past(seq_byte));
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("start address high byte not written first");

  property p_map_last;
    @(posedge pclk) disable iff (!presetn)
    (state == S_MAP_WR && accepted && last_map) |=>
      (state == S_LOAD && phase == 2'h0 && ptr == $past(ptr) + 16'h0001);
  endproperty
  a_map_last: assert property (p_map_last)
    else $error("copy did not return to the sequence list");

  property p_cmd_step;
    @(posedge pclk) disable iff (!presetn)
    (state == S_SEQ_WR && accepted && phase == 2'h0 && !is_data) |=>
      (ptr == $past(ptr) + 16'h0001 && ee_data == $past(cur_instr));
  endproperty
  a_cmd_step: assert property (p_cmd_step)
    else $error("command byte not stored unchanged with one step");

  property p_store_end;
    @(posedge pclk) disable iff (!presetn)
    (state == S_LOAD && seq_end) |=>
      (state == S_IDLE && done && !store_busy && !ee_valid);
  endproperty
  a_store_end: assert property (p_store_end)
    else $error("store did not finish after the last entry");

  property p_map_pulse;
    @(posedge pclk) disable iff (!presetn)
    map_rd |=> (!map_rd && state == S_MAP_CAP);
  endproperty
  a_map_pulse: assert property (p_map_pulse)
    else $error("map read not a single pulse");
endmodule // eeprom_store_sequencer

// *** verif/ee_partner.sv ***
// Register map and serial eeprom model for the store sequencer bench
`timescale 1ns/100ps
module ee_partner (
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Async reset, low
  input  wire logic        map_rd,     // Map read pulse
  input  wire logic [15:0] map_addr,   // Map address
  output logic      [7:0]  map_rdata,  // Map data
  input  wire logic        ee_valid,   // Byte write request
  input  wire logic [15:0] ee_addr,    // Byte address
  input  wire logic [7:0]  ee_data,    // Byte
  output logic             ee_ready,   // Byte accepted
  input  wire logic [3:0]  slow        // Wait cycles before accept
);
  logic [7:0]  dat_log [0:255];
  logic [15:0] adr_log [0:255];
  int          n_wr = 0;
  logic [3:0]  cnt;
  wire  [7:0]  mval = map_addr[7:0] ^ {map_addr[11:8], map_addr[15:12]}
                      ^ 8'h3c;
  // -------------------------------------
  // Map answers next cycle, else toggles
  // -------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_rdata <= 8'h00;
      ee_ready <= 1'b0;
      cnt <= 4'h0;
    end else begin
      map_rdata <= map_rd ? mval : ~map_rdata;
      if (ee_valid && ee_ready) begin
        dat_log[n_wr[7:0]] <= ee_data;
        adr_log[n_wr[7:0]] <= ee_addr;
        n_wr <= n_wr + 1;
        ee_ready <= 1'b0;
        cnt <= 4'h0;
      end else if (ee_valid && cnt >= slow) begin
        ee_ready <= 1'b1;
      end else if (ee_valid) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // ee_partner

// *** verif/eeprom_store_sequencer_bench.sv ***
// Testbench for the eeprom store sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module eeprom_store_sequencer_bench;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [15:0] paddr, map_addr, ee_addr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, map_rd, ee_valid, ee_ready, store_busy;
  logic [7:0]  map_rdata, ee_data;
  logic [3:0]  slow;
  int          n_fail, comparisons, cycles;
  logic [7:0]  dflt [0:10] = '{8'h01, 8'h00, 8'hfe, 8'h1f, 8'h01, 8'h00,
                               8'h08, 8'h02, 8'h00, 8'h80, 8'h91};
  logic [7:0]  seq [0:10];
  logic [7:0]  exp_q [$];

  eeprom_store_sequencer dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .map_rd(map_rd), .map_addr(map_addr), .map_rdata(map_rdata),
    .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data),
    .ee_ready(ee_ready), .store_busy(store_busy));
  ee_partner ee_u (.pclk(pclk), .presetn(presetn), .map_rd(map_rd),
    .map_addr(map_addr), .map_rdata(map_rdata), .ee_valid(ee_valid),
    .ee_addr(ee_addr), .ee_data(ee_data), .ee_ready(ee_ready),
    .slow(slow));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [15:0] eaddr(input int i);
    return {store_seq_pkg::SEQ_FIRST_IDX + 14'(i), 2'b00};
  endfunction

  function automatic logic [7:0] mval(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
  endfunction

  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // -------------------------------------
  // Expected byte stream from the list
  // -------------------------------------
  function automatic void build();
    int i;
    int n;
    logic [15:0] a;
    exp_q = {};
    i = 0;
    while (i < 11) begin
      exp_q.push_back(seq[i]);
      if (seq[i][7:5] == 3'h0) begin
        for (n = 1; n < 3 && i + n < 11; n++) exp_q.push_back(seq[i+n]);
        if (i < 9) begin
          a = {seq[i+1], seq[i+2]};
          for (n = 0; n <= seq[i]; n++) exp_q.push_back(mval(a + 16'(n)));
        end
        i += 3;
      end else begin
        i++;
      end
    end
  endfunction

  task automatic run_store(input logic [3:0] s);
    int base;
    build();
    slow <= s;
    base = ee_u.n_wr;
    apb(16'h0000, 1'b1, 32'h1);
    while (store_busy !== 1'b1) @(posedge pclk);
    apb(16'h0004, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'b01)
    apb(16'h0000, 1'b1, 32'h1);
    while (store_busy !== 1'b0) @(posedge pclk);
    `CHK(ee_u.n_wr - base, exp_q.size())
    for (int k = 0; k < exp_q.size(); k++) begin
      `CHK(ee_u.dat_log[base+k], exp_q[k])
      `CHK(ee_u.adr_log[base+k], 16'(k))
    end
    apb(16'h0008, 1'b0, 32'h0);
    `CHK(rd, 32'(exp_q.size()))
    apb(16'h0004, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'b10)
  endtask

  task automatic t_defaults;
    for (int i = 0; i < 11; i++) begin
      apb(eaddr(i), 1'b0, 32'h0);
      `CHK(rd, {24'h0, dflt[i]})
    end
    apb(16'h1000, 1'b0, 32'h0);
    `CHK(err, 1'b1)
    seq = dflt;
  endtask

  // -------------------------------------
  // Single-byte copy, changed command
  // -------------------------------------
  task automatic t_custom;
    logic [7:0] nv [0:3] = '{8'h00, 8'h00, 8'h10, 8'hc5};
    int idx [0:3] = '{0, 1, 2, 10};
    for (int i = 0; i < 4; i++) begin
      apb(eaddr(idx[i]), 1'b1, {24'h0, nv[i]});
      seq[idx[i]] = nv[i];
    end
    apb(eaddr(10), 1'b0, 32'h0);
    `CHK(rd, 32'h000000c5)
    run_store(4'h3);
    apb(eaddr(9), 1'b1, 32'h00000005);
    seq[9] = 8'h05;
    run_store(4'h1);
  endtask

  // -------------------------------------
  // Reset after the last store restores the default list
  // -------------------------------------
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(store_busy, 1'b0)
    presetn <= 1'b1;
    apb(16'h0004, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'b00)
    t_defaults();
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    slow = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    run_store(4'h0);
    t_custom();
    t_reset();
    report_and_stop();
  end
endmodule // eeprom_store_sequencer_bench
